//--- rtl/cps_params.svh
// Register offsets, field positions, reset values and timing counts for the port status page
// Notes on behaviour
// - Fault flag sets on resume or suspend fault; port then reports suspended.
// - Resume fault: no peer bias while resuming; suspend fault: bias while suspending.
// - Writing one clears fault; hardware reset clears it; bus reset leaves it.
// - Standby error flag sets on standby error, clears when standby is left.
// - Write of one or remote clear command clears standby flag and error record.
// - Scrambler-off bit high sends packet data unscrambled.
// - Beta-only bit always reads zero.
// - DC-link-detected bit follows the legacy connect-detect circuit.
// - Three-bit speed ceiling: 000 S100 up to 101 S3200; 110, 111 reserved.
// - Ceiling writes above port capability store the port maximum instead.
// - Ceiling used only at new beta connection; resets to port maximum.
// - Local plug flag reads one permanently.
// - Read-only capability field reports port maximum speed, same encoding.
// - Link-unreliable sets on negotiation or sync failure; write one clears.
// - Beta-operation reads one in beta mode, zero in legacy or disconnected.
// - Connected, receive ok and not beta means active legacy mode.
// - Eight-bit error counter counts invalid codewords, saturating at 255.
// - Any read of the error counter clears it, remote reads included.
// - Loop-block flag sets on loop disable; bus reset or disconnect clears.
// - Standby-state flag reads one while port is in standby.
// - Disabled with deep disable: no AC status, no toning, connected and rx ok low.
// - Port-off bit disables port; disabled port tones and never goes legacy-active, but still reports beta op on a beta link.
// - Connected flag sets only after about 341 ms of stable connection.
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_ADDR_W         8
`define CPS_OFS_CTRL       8'h00
`define CPS_OFS_STATUS     8'h04
`define CPS_OFS_SPEED      8'h08
`define CPS_OFS_ERRCNT     8'h0C
`define CPS_CTRL_OFF_BIT   0
`define CPS_CTRL_SCR_BIT   1
`define CPS_CTRL_DEEP_BIT  2
`define CPS_ST_FAULT_BIT   0
`define CPS_ST_SBF_BIT     1
`define CPS_ST_UNREL_BIT   2
`define CPS_SPEED_W        3
`define CPS_SPEED_MAX      3'h3
`define CPS_ERR_MAX        8'hFF
`define CPS_DEBOUNCE_MS    341
`define CPS_CLK_KHZ        200000
`define CPS_DEBOUNCE_CYC   (`CPS_DEBOUNCE_MS * `CPS_CLK_KHZ)
`endif

//--- rtl/cps_pkg.sv
// Types shared by the port status page
package cps_pkg;
  typedef struct packed {
    logic resuming;
    logic suspending;
    logic peer_bias;
    logic standby_err;
    logic standby;
    logic remote_sbf_clr;
    logic neg_fail;
    logic sync_fail;
    logic loop_disable;
    logic bus_reset;
    logic dc_detect;
    logic beta;
    logic rx_valid;
    logic raw_connect;
    logic bad_codeword;
    logic remote_err_read;
  } cps_event_type;

  typedef struct packed {
    logic       suspended;
    logic       scramble_off;
    logic       toning;
    logic       ac_track;
    logic       connected;
    logic       receive_ok_flag;
    logic       beta_op;
    logic       legacy_active;
    logic [2:0] speed_ceiling;
  } cps_phy_ctl_type;

  typedef enum logic [2:0] {
    CPS_DISCON = 3'b001,
    CPS_DEBNC  = 3'b010,
    CPS_CONN   = 3'b100
  } cps_conn_type;
endpackage

//--- rtl/cps_port_status.sv
// Per-port status and control page with APB register access
`timescale 1ns/100ps
`include "cps_params.svh"
module cps_port_status #(
  parameter int unsigned    DEBOUNCE_CYC = `CPS_DEBOUNCE_CYC,
  parameter logic [2:0]     PORT_MAX_SPEED = `CPS_SPEED_MAX
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [31:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire cps_pkg::cps_event_type evt_i,
  output cps_pkg::cps_phy_ctl_type    phy_o
);
  import cps_pkg::*;

  // Capability codes above the top encoding are reserved
  if (DEBOUNCE_CYC < 1 || PORT_MAX_SPEED > 3'h5) begin : g_param_check
    $error("Bad parameters");
  end

  // Pins from the cable side cross into this clock via two flops
  cps_event_type sync1;
  cps_event_type evt;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1 <= '0;
      evt   <= '0;
    end else begin
      sync1 <= evt_i;
      evt   <= sync1;
    end
  end

  // APB decode
  wire       access   = psel_i && penable_i && pready_o;
  wire       wr       = access && pwrite_i;
  // Read side effects at the prdata capture edge, so no count slips between
  wire       rd       = psel_i && penable_i && !pready_o && !pwrite_i;
  wire [7:0] ofs      = paddr_i[7:0];
  wire       hi_zero  = (paddr_i[31:8] == 24'h0);
  wire       sel_ctrl = hi_zero && ofs == `CPS_OFS_CTRL;
  wire       sel_st   = hi_zero && ofs == `CPS_OFS_STATUS;
  wire       sel_spd  = hi_zero && ofs == `CPS_OFS_SPEED;
  wire       sel_err  = hi_zero && ofs == `CPS_OFS_ERRCNT;
  wire       mapped   = sel_ctrl | sel_st | sel_spd | sel_err;

  logic       port_off;
  logic       scr_off;
  logic       deep_dis;
  logic       fault;
  logic       sb_fault;
  logic       unreliable;
  logic       loop_blk;
  logic [2:0] ceiling;
  logic [7:0] err_cnt;
  logic [31:0] ctr;
  cps_conn_type conn_st;

  wire hard_off = port_off && deep_dis;
  wire con      = (conn_st == CPS_CONN) && !hard_off;
  wire rx_ok    = con && evt.rx_valid && !port_off;
  wire beta_op  = con && evt.beta;

  wire wr_st      = wr && sel_st;
  wire fault_evt  = (evt.resuming && !evt.peer_bias) || (evt.suspending && evt.peer_bias);
  wire sbf_clr    = (wr_st && pwdata_i[`CPS_ST_SBF_BIT]) || evt.remote_sbf_clr;
  wire unrel_evt  = evt.neg_fail || evt.sync_fail;
  wire [2:0] wspd = pwdata_i[2:0];
  wire [2:0] next_ceiling = (wspd > PORT_MAX_SPEED) ? PORT_MAX_SPEED : wspd;
  wire       err_rd  = (rd && sel_err) || evt.remote_err_read;
  wire [7:0] err_inc = (err_cnt == `CPS_ERR_MAX) ? err_cnt : err_cnt + 8'h01;

  wire [31:0] rd_ctrl = {29'h0, deep_dis, scr_off, port_off};
  // Bit layout: 0 fault, 1 standby fault, 2 unreliable, 3 beta-only(0), 4 dc link,
  // 5 local plug, 6 beta op, 7 loop block, 8 standby, 9 connected, 10 receive ok
  wire [31:0] rd_st = {21'h0, rx_ok, con, evt.standby, loop_blk, beta_op, 1'b1,
                       evt.dc_detect, 1'b0, unreliable, sb_fault, fault};
  wire [31:0] rd_spd = {25'h0, PORT_MAX_SPEED, 1'b0, ceiling};
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                       sel_st   ? rd_st   :
                       sel_spd  ? rd_spd  :
                       sel_err  ? {24'h0, err_cnt} : 32'h0;

  // One wait state: ready rises in the access phase, drops after completion
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
      prdata_o  <= (psel_i && penable_i && !pready_o) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_off <= 1'b0;
      scr_off  <= 1'b0;
      deep_dis <= 1'b0;
      ceiling  <= PORT_MAX_SPEED;
    end else begin
      if (wr && sel_ctrl) begin
        port_off <= pwdata_i[`CPS_CTRL_OFF_BIT];
        scr_off  <= pwdata_i[`CPS_CTRL_SCR_BIT];
        deep_dis <= pwdata_i[`CPS_CTRL_DEEP_BIT];
      end
      if (wr && sel_spd) begin
        ceiling <= next_ceiling;
      end
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault      <= 1'b0;
      sb_fault   <= 1'b0;
      unreliable <= 1'b0;
      loop_blk   <= 1'b0;
    end else begin
      if (fault_evt) fault <= 1'b1;
      else if (wr_st && pwdata_i[`CPS_ST_FAULT_BIT]) fault <= 1'b0;
      if (evt.standby_err && evt.standby) sb_fault <= 1'b1;
      else if (sbf_clr || !evt.standby) sb_fault <= 1'b0;
      if (unrel_evt) unreliable <= 1'b1;
      else if (wr_st && pwdata_i[`CPS_ST_UNREL_BIT]) unreliable <= 1'b0;
      if (evt.loop_disable) loop_blk <= 1'b1;
      else if (evt.bus_reset || !con) loop_blk <= 1'b0;
    end
  end

  // Invalid codeword counter; an increment coinciding with a read is kept
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_cnt <= 8'h00;
    end else if (err_rd) begin
      err_cnt <= evt.bad_codeword ? 8'h01 : 8'h00;
    end else if (evt.bad_codeword) begin
      err_cnt <= err_inc;
    end
  end

  // Connection debounce
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conn_st <= CPS_DISCON;
      ctr     <= 32'h0;
    end else begin
      unique case (conn_st)
        CPS_DISCON: begin
          ctr <= 32'h0;
          if (evt.raw_connect && !hard_off) conn_st <= CPS_DEBNC;
        end
        CPS_DEBNC: begin
          if (!evt.raw_connect || hard_off) begin
            conn_st <= CPS_DISCON;
          end else if (ctr == DEBOUNCE_CYC - 1) begin
            conn_st <= CPS_CONN;
          end else begin
            ctr <= ctr + 32'h1;
          end
        end
        CPS_CONN: begin
          if (!evt.raw_connect || hard_off) conn_st <= CPS_DISCON;
        end
      endcase
    end
  end

  // The ceiling is latched for the PHY only as a beta link comes up
  logic beta_q;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phy_o  <= '0;
      beta_q <= 1'b0;
    end else begin
      beta_q <= beta_op;
      phy_o.suspended       <= fault | fault_evt;
      phy_o.scramble_off    <= scr_off;
      phy_o.toning          <= !hard_off;
      phy_o.ac_track        <= !hard_off;
      phy_o.connected       <= con;
      phy_o.receive_ok_flag <= rx_ok;
      phy_o.beta_op         <= beta_op;
      phy_o.legacy_active   <= con && rx_ok && !beta_op;
      if (beta_op && !beta_q) phy_o.speed_ceiling <= ceiling;
    end
  end

  property p_fault_sets;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      fault_evt |=> fault;
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("Fault not set");
  property p_fault_clr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_st && pwdata_i[0] && !fault_evt |=> !fault;
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("Fault not cleared");
  property p_sbf_exit;
    @(posedge sys_clk_i) disable iff (!reset_n_i) !evt.standby && !evt.standby_err |=> !sb_fault;
  endproperty
  a_sbf_exit: assert property (p_sbf_exit) else $error("Standby fault kept");
  property p_ceil_cap;
    @(posedge sys_clk_i) disable iff (!reset_n_i) ceiling <= PORT_MAX_SPEED;
  endproperty
  a_ceil_cap: assert property (p_ceil_cap) else $error("Ceiling above capability");
  property p_err_sat;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      err_cnt == 8'hFF && !err_rd |=> err_cnt == 8'hFF;
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("Counter wrapped");
  property p_err_rd;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      err_rd && !evt.bad_codeword |=> err_cnt == 8'h00;
  endproperty
  a_err_rd: assert property (p_err_rd) else $error("Counter not cleared");
  property p_deep;
    @(posedge sys_clk_i) disable iff (!reset_n_i) hard_off |=> !phy_o.connected && !phy_o.toning;
  endproperty
  a_deep: assert property (p_deep) else $error("Deep disable ignored");
  property p_off_rx;
    @(posedge sys_clk_i) disable iff (!reset_n_i) port_off |=> !phy_o.receive_ok_flag;
  endproperty
  a_off_rx: assert property (p_off_rx) else $error("Disabled port active");
  property p_scr;
    @(posedge sys_clk_i) disable iff (!reset_n_i) scr_off |=> phy_o.scramble_off;
  endproperty
  a_scr: assert property (p_scr) else $error("Scrambler not off");

  // Flag, output and read-path checks
  property p_sbf_set;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      evt.standby_err && evt.standby |=> sb_fault;
  endproperty
  a_sbf_set: assert property (p_sbf_set) else $error("Standby fault not set");

  property p_sbf_clr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      sbf_clr && !(evt.standby_err && evt.standby) |=> !sb_fault;
  endproperty
  a_sbf_clr: assert property (p_sbf_clr) else $error("Standby fault not cleared");

  property p_unrel_set;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      unrel_evt |=> unreliable;
  endproperty
  a_unrel_set: assert property (p_unrel_set) else $error("Unreliable not set");

  property p_unrel_clr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_st && pwdata_i[`CPS_ST_UNREL_BIT] && !unrel_evt |=> !unreliable;
  endproperty
  a_unrel_clr: assert property (p_unrel_clr) else $error("Unreliable not cleared");

  property p_loop_set;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      evt.loop_disable |=> loop_blk;
  endproperty
  a_loop_set: assert property (p_loop_set) else $error("Loop block not set");

  property p_loop_clr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (evt.bus_reset || !con) && !evt.loop_disable |=> !loop_blk;
  endproperty
  a_loop_clr: assert property (p_loop_clr) else $error("Loop block kept");

  property p_susp_out;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      fault |=> phy_o.suspended;
  endproperty
  a_susp_out: assert property (p_susp_out) else $error("Port not suspended");

  property p_rd_const;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      psel_i && penable_i && !pready_o && sel_st |=> !prdata_o[3] && prdata_o[5];
  endproperty
  a_rd_const: assert property (p_rd_const) else $error("Fixed status bits wrong");

  property p_rd_cap;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      psel_i && penable_i && !pready_o && sel_spd |=> prdata_o[6:4] == PORT_MAX_SPEED;
  endproperty
  a_rd_cap: assert property (p_rd_cap) else $error("Capability field wrong");

  property p_beta_disc;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      !con |=> !phy_o.beta_op;
  endproperty
  a_beta_disc: assert property (p_beta_disc) else $error("Beta while disconnected");

  property p_legacy;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      con && rx_ok && !beta_op |=> phy_o.legacy_active;
  endproperty
  a_legacy: assert property (p_legacy) else $error("Legacy mode not active");

  property p_debounce;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      conn_st == CPS_DEBNC && ctr != DEBOUNCE_CYC - 1 |=> conn_st != CPS_CONN;
  endproperty
  a_debounce: assert property (p_debounce) else $error("Connected too early");

  property p_err_inc;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      evt.bad_codeword && !err_rd && err_cnt != 8'hFF |=> err_cnt == $past(err_cnt) + 8'h01;
  endproperty
  a_err_inc: assert property (p_err_inc) else $error("Codeword not counted");

  property p_ceil_latch;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      beta_op && !beta_q |=> phy_o.speed_ceiling == $past(ceiling);
  endproperty
  a_ceil_latch: assert property (p_ceil_latch) else $error("Ceiling not latched");

  property p_tone_on;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      port_off && !deep_dis |=> phy_o.toning;
  endproperty
  a_tone_on: assert property (p_tone_on) else $error("Disabled port stopped toning");

  property p_ceil_wr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      wr && sel_spd && wspd <= PORT_MAX_SPEED |=> ceiling == $past(wspd);
  endproperty
  a_ceil_wr: assert property (p_ceil_wr) else $error("Ceiling write lost");

  property p_ready_pulse;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready longer than one cycle");

  property p_slverr;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      psel_i && penable_i && !pready_o && !mapped |=> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("Unmapped access not refused");
  c_conn: cover property (@(posedge sys_clk_i) conn_st == CPS_CONN);
  c_fault: cover property (@(posedge sys_clk_i) fault);
  c_sat: cover property (@(posedge sys_clk_i) err_cnt == 8'hFF);
  c_beta: cover property (@(posedge sys_clk_i) phy_o.beta_op);
  c_sbf: cover property (@(posedge sys_clk_i) sb_fault);
endmodule

//--- tb/cps_peer_model.sv
// Peer port model: cable bias, connect detect, beta link and codeword errors
`timescale 1ns/100ps
module cps_peer_model (
  input  wire logic              sys_clk_i,
  input  wire logic              plug_i,
  input  wire logic              beta_i,
  input  wire logic              go_i,
  input  wire logic [8:0]        bad_n_i,
  output cps_pkg::cps_event_type peer_o
);
  import cps_pkg::*;
  logic [8:0] left = 9'h000;
  always @(posedge sys_clk_i) begin
    if (go_i) begin
      left <= bad_n_i;
    end else if (left != 9'h000) begin
      left <= left - 9'h001;
    end
  end
  // Bias and detect drop as soon as the cable is pulled
  always_comb begin
    peer_o              = '0;
    peer_o.peer_bias    = plug_i;
    peer_o.raw_connect  = plug_i;
    peer_o.dc_detect    = plug_i & ~beta_i;
    peer_o.rx_valid     = plug_i;
    peer_o.beta         = plug_i & beta_i;
    peer_o.bad_codeword = (left != 9'h000);
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the port status page
`timescale 1ns/100ps
module tb;
  import cps_pkg::*;
  localparam logic [15:0] RES = 16'h8000, SUS = 16'h4000, SBE = 16'h1000, SBY = 16'h0800;
  localparam logic [15:0] RCLR = 16'h0400, NEG = 16'h0200, SYN = 16'h0100, LOOP = 16'h0080;
  localparam logic [15:0] BRST = 16'h0040, RERD = 16'h0001;
  logic            clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [31:0]     pa = '0, pwd = '0, prd;
  logic            prdy, perr, plug = 1'h0, beta = 1'h0, go = 1'h0;
  logic [8:0]      nbad = '0;
  logic [7:0]      r = 8'h4B;
  logic [2:0]      v;
  logic [40:0]     q[$], e;
  cps_event_type   ev = '0, peer, evt;
  cps_phy_ctl_type phy;
  int              n_errors = 0, samples_checked = 0, cyc = 0;
  always #2.5 clk = ~clk;
  assign evt = ev | peer;
  cps_port_status #(.DEBOUNCE_CYC(8)) dut_u (.sys_clk_i(clk), .reset_n_i(rst_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .evt_i(evt), .phy_o(phy));
  cps_peer_model peer_u (.sys_clk_i(clk), .plug_i(plug), .beta_i(beta), .go_i(go),
    .bad_n_i(nbad), .peer_o(peer));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d, input logic [32:0] x);
    @(posedge clk);
    if (!w) q.push_back({a[7:0], x});
    psel  <= 1'h1;
    pwr   <= w;
    pa    <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (prdy !== 1'h1);
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'h1, a, d, '0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] x);
    xfer(1'h0, a, '0, x);
  endtask
  task automatic evs(input logic [15:0] m, input logic on);
    @(posedge clk);
    ev <= on ? (ev | m) : (ev & ~m);
    repeat (6) @(posedge clk);
  endtask
  task automatic evp(input logic [15:0] m);
    evs(m, 1'h1);
    evs(m, 1'h0);
  endtask
  task automatic burst(input logic [8:0] n);
    @(posedge clk);
    nbad <= n;
    go   <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (n + 10) @(posedge clk);
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read results are judged when they appear, against the oldest note
  always @(posedge clk) begin
    if (psel && pen && !pwr && prdy === 1'h1) begin
      e = q.pop_front();
      chk($sformatf("reg %h", e[40:33]), {perr, prd}, e[32:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(32'h00, 33'h000);
    rd(32'h04, 33'h020);
    rd(32'h08, 33'h033);
    rd(32'h0C, 33'h000);
    rd(32'h10, 33'h100000000);
    wr(32'h100, 32'h1);
    rd(32'h100, 33'h100000000);
    rd(32'h00, 33'h000);
    wr(32'h08, 32'h5);
    rd(32'h08, 33'h033);
    r = lfsr(r);
    v = r[2:0] % 3'h6;
    wr(32'h08, {29'h0, v});
    rd(32'h08, 33'h030 | 33'((v > 3'h3) ? 3'h3 : v));
    wr(32'h00, 32'h2);
    repeat (2) @(posedge clk);
    chk("scramble_off", 33'(phy.scramble_off), 33'h1);
    rd(32'h00, 33'h002);
    wr(32'h00, 32'h0);
    evp(RES);
    rd(32'h04, 33'h021);
    chk("suspended", 33'(phy.suspended), 33'h1);
    evp(BRST);
    rd(32'h04, 33'h021);
    wr(32'h04, 32'h1);
    rd(32'h04, 33'h020);
    for (int k = 0; k < 2; k++) begin
      evp(k == 0 ? NEG : SYN);
      rd(32'h04, 33'h024);
      wr(32'h04, 32'h4);
      rd(32'h04, 33'h020);
    end
    evs(SBY, 1'h1);
    rd(32'h04, 33'h120);
    evp(SBE);
    rd(32'h04, 33'h122);
    wr(32'h04, 32'h2);
    rd(32'h04, 33'h120);
    evp(SBE);
    evp(RCLR);
    rd(32'h04, 33'h120);
    evp(SBE);
    evs(SBY, 1'h0);
    rd(32'h04, 33'h020);
    burst(9'h12C);
    rd(32'h0C, 33'h0FF);
    rd(32'h0C, 33'h000);
    r = lfsr(r);
    burst({1'h0, r});
    rd(32'h0C, {25'h0, r});
    burst(9'h005);
    evp(RERD);
    rd(32'h0C, 33'h000);
    @(posedge clk);
    plug <= 1'h1;
    repeat (30) @(posedge clk);
    rd(32'h04, 33'h630);
    chk("legacy_active", 33'(phy.legacy_active), 33'h1);
    chk("receive_ok", 33'(phy.receive_ok_flag), 33'h1);
    evp(SUS);
    rd(32'h04, 33'h631);
    wr(32'h04, 32'h1);
    evp(LOOP);
    rd(32'h04, 33'h6B0);
    evp(BRST);
    rd(32'h04, 33'h630);
    wr(32'h00, 32'h1);
    repeat (6) @(posedge clk);
    rd(32'h04, 33'h230);
    chk("toning", 33'(phy.toning), 33'h1);
    chk("receive_ok", 33'(phy.receive_ok_flag), 33'h0);
    chk("connected", 33'(phy.connected), 33'h1);
    chk("ac_track", 33'(phy.ac_track), 33'h1);
    wr(32'h00, 32'h5);
    repeat (6) @(posedge clk);
    rd(32'h04, 33'h030);
    chk("toning", 33'(phy.toning), 33'h0);
    chk("ac_track", 33'(phy.ac_track), 33'h0);
    chk("connected", 33'(phy.connected), 33'h0);
    wr(32'h00, 32'h0);
    repeat (30) @(posedge clk);
    evp(LOOP);
    plug <= 1'h0;
    repeat (6) @(posedge clk);
    rd(32'h04, 33'h020);
    wr(32'h08, 32'h2);
    plug <= 1'h1;
    beta <= 1'h1;
    repeat (30) @(posedge clk);
    rd(32'h04, 33'h660);
    chk("ceiling", 33'(phy.speed_ceiling), 33'h2);
    chk("beta_op", 33'(phy.beta_op), 33'h1);
    close_out();
  end
endmodule
